//--- io_space_register_decoder.sv
// Purpose: low I/O space register decoder for the processor core
// Assumes: core requests are on clk; pin inputs are asynchronous
// Notes:   one request per enabled cycle, answered on the following one
//
// Behaviour
// - bit set and clear work only on I/O addresses 0x00 to 0x1F
// - bit test on low registers gives the core its skip decision
// - status flags clear on a written one; a written zero leaves them
// - single-bit set or clear touches only the addressed bit
// - I/O transfers use a six-bit address, 0x00 to 0x3F
// - data-space accesses see each I/O register at address plus 0x20
// - extended space 0x60 to 0xFF is never reached by I/O transfers
`timescale 1ns/10ps
`default_nettype none

module io_space_register_decoder #(
	parameter int STORE_SLOTS = io_space_pkg::NUM_STORE,
	parameter int FLAG_REGS = io_space_pkg::NUM_FLAG,
	parameter int PORT_COUNT = io_space_pkg::NUM_PORT
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic sys_rst,
	input wire logic reqValid,
	input wire io_space_pkg::cmd_t reqCmd,
	input wire logic [7:0] reqAddr,
	input wire logic [2:0] reqBit,
	input wire logic [7:0] reqData,
	output logic rspValid,
	output logic rspHit,
	output logic rspSkip,
	output logic [7:0] rspData,
	input wire logic [io_space_pkg::NUM_PORT-1:0][7:0] portPins,
	input wire logic [io_space_pkg::NUM_FLAG-1:0][7:0] flagEvents,
	output logic [io_space_pkg::NUM_FLAG-1:0][7:0] flagValues,
	output logic [io_space_pkg::NUM_STORE-1:0][7:0] regValues,
	output logic [1:0] forceCompare
);
	import io_space_pkg::*;

	// ------------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------------
	// the address map is fixed, so the counts must match it exactly
	if (STORE_SLOTS != NUM_STORE || FLAG_REGS != NUM_FLAG ||
			PORT_COUNT != NUM_PORT) begin : badCounts
		$error("io_space_register_decoder counts must match the map");
	end

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PORT-1:0][7:0] sync1;
		logic [NUM_PORT-1:0][7:0] sync2;
		logic [NUM_PORT-1:0][7:0] sync3;
		logic [NUM_PORT-1:0][7:0] pinVal;
		logic [NUM_FLAG-1:0][7:0] flags;
		logic rspValid;
		logic rspHit;
		logic rspSkip;
		logic rspFromStore;
		logic [7:0] rspLocal;
		logic [1:0] forcePulse;
	} dec_state_t;

	localparam dec_state_t RESET_STATE = '{
		sync1: {NUM_PORT{RESET_PIN}},
		sync2: {NUM_PORT{RESET_PIN}},
		sync3: {NUM_PORT{RESET_PIN}},
		pinVal: {NUM_PORT{RESET_PIN}},
		flags: {NUM_FLAG{RESET_FLAG}},
		rspValid: 1'b0,
		rspHit: 1'b0,
		rspSkip: 1'b0,
		rspFromStore: 1'b0,
		rspLocal: 8'h00,
		forcePulse: 2'b00
	};

	dec_state_t st_reg;
	dec_state_t st_next;

	store_if #(.W(DATA_W), .N(NUM_STORE)) storeBus ();

	// ------------------------------------------------------------------
	// decode signals
	// ------------------------------------------------------------------
	logic taken;
	logic isIoCmd;
	logic isBitOp;
	logic isWrite;
	logic dataInIo;
	logic [5:0] ioAddr;
	map_entry_t entry;
	logic hit;
	logic [7:0] curVal;
	logic [7:0] bitHot;
	logic [7:0] newVal;
	logic [7:0] clearBits;
	logic testBit;
	logic [4:0] flagIdx;
	logic [7:0] evSel;
	logic [7:0] clr;

	// ------------------------------------------------------------------
	// request decode and address translation
	// ------------------------------------------------------------------
	// a request is only taken on an enabled edge
	assign taken = reqValid && ce;
	assign isIoCmd = (reqCmd != DATA_LOAD) && (reqCmd != DATA_STORE);
	assign isBitOp = (reqCmd == SET_IO_BIT_INSTR) ||
		(reqCmd == CLEAR_IO_BIT_INSTR) ||
		(reqCmd == SKIP_IF_IO_BIT_SET_INSTR) ||
		(reqCmd == SKIP_IF_IO_BIT_CLEAR_INSTR);
	assign isWrite = (reqCmd == IO_WRITE) || (reqCmd == DATA_STORE) ||
		(reqCmd == SET_IO_BIT_INSTR) || (reqCmd == CLEAR_IO_BIT_INSTR);

	// only 0x20..0x5F of data space mirrors the I/O registers
	assign dataInIo = (reqAddr >= DATA_SPACE_OFFSET) &&
		(reqAddr < EXT_IO_FIRST);

	// upper address bits are dropped for I/O transfers, so the extended
	// range can never be reached by them
	assign ioAddr = isIoCmd ? reqAddr[5:0] :
		6'(reqAddr - DATA_SPACE_OFFSET);

	assign entry = lookup(ioAddr);
	assign flagIdx = entry.idx;

	// bit ops above the low 32 locations fall through as misses
	assign hit = taken && (entry.kind != KIND_NONE) &&
		(isIoCmd || dataInIo) &&
		(!isBitOp || ioAddr <= BIT_IO_LAST);

	// ------------------------------------------------------------------
	// current value and modified value
	// ------------------------------------------------------------------
	// unimplemented bits are masked here so they always read zero
	always_comb begin
		case (entry.kind)
			KIND_STORE: curVal = storeBus.contents[entry.idx] & entry.mask;
			KIND_FLAG: curVal = st_reg.flags[entry.idx] & entry.mask;
			KIND_PIN: curVal = st_reg.pinVal[entry.idx] & entry.mask;
			default: curVal = 8'h00;
		endcase
	end

	assign bitHot = 8'h01 << reqBit;
	assign testBit = |(curVal & bitHot);

	// read-modify-write keeps every bit but the addressed one
	always_comb begin
		case (reqCmd)
			SET_IO_BIT_INSTR: newVal = curVal | bitHot;
			CLEAR_IO_BIT_INSTR: newVal = curVal & ~bitHot;
			default: newVal = reqData;
		endcase
	end

	// which flag bits a write asks to clear; a bit clear writes a zero
	// and so clears nothing, a bit set writes one to a single flag only
	always_comb begin
		clearBits = 8'h00;
		if (hit && isWrite && entry.kind == KIND_FLAG) begin
			case (reqCmd)
				SET_IO_BIT_INSTR: clearBits = bitHot & entry.mask;
				CLEAR_IO_BIT_INSTR: clearBits = 8'h00;
				default: clearBits = reqData & entry.mask;
			endcase
		end
	end

	assign evSel = flagEvents[flagIdx] & entry.mask;

	// ------------------------------------------------------------------
	// slot store port
	// ------------------------------------------------------------------
	// writes to reserved places never reach the store, and reserved bits
	// are dropped on the way in
	assign storeBus.we = hit && isWrite &&
		(entry.kind == KIND_STORE);
	assign storeBus.waddr = entry.idx;
	assign storeBus.wdata = newVal & entry.mask;
	assign storeBus.re = hit && (entry.kind == KIND_STORE);
	assign storeBus.raddr = entry.idx;

	reg_slot_store #(
		.W(DATA_W),
		.N(NUM_STORE),
		.RESET_VALUE(RESET_RW)
	) reg_slot_store_inst (
		.clk(clk),
		.ce(ce),
		.sys_rst(sys_rst),
		.bus(storeBus.store)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		clr = 8'h00;

		// pins: three flops, a change counts once stages two and three agree
		st_next.sync1 = portPins;
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		for (int p = 0; p < NUM_PORT; p++) begin
			st_next.pinVal[p] = (~(st_reg.sync2[p] ^ st_reg.sync3[p]) &
				st_reg.sync3[p]) | ((st_reg.sync2[p] ^ st_reg.sync3[p]) &
				st_reg.pinVal[p]);
		end

		// flags: a hardware event in the clearing cycle wins over the clear
		for (int i = 0; i < NUM_FLAG; i++) begin
			clr = (int'(flagIdx) == i) ? clearBits : 8'h00;
			st_next.flags[i] = (st_reg.flags[i] & ~clr) |
				(flagEvents[i] & flagMask(i));
		end

		// answer: reads return the value seen before this access writes
		st_next.rspValid = taken;
		st_next.rspHit = hit;
		st_next.rspFromStore = hit && (entry.kind == KIND_STORE);
		st_next.rspLocal = hit ? curVal : 8'h00;
		st_next.rspSkip = hit &&
			(((reqCmd == SKIP_IF_IO_BIT_SET_INSTR) && testBit) ||
			((reqCmd == SKIP_IF_IO_BIT_CLEAR_INSTR) && !testBit));

		// force bits are strobes: they act once and are never stored
		st_next.forcePulse = 2'b00;
		if (storeBus.we && ioAddr == OFF_TIMER0_CONTROL_B) begin
			st_next.forcePulse = newVal[FORCE_MSB:FORCE_LSB];
		end
	end

	// everything holds while the clock enable is low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= RESET_STATE;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// store words come out of the store's own read register
	assign rspData = st_reg.rspFromStore ? storeBus.rdata : st_reg.rspLocal;
	assign rspValid = st_reg.rspValid;
	assign rspHit = st_reg.rspHit;
	assign rspSkip = st_reg.rspSkip;
	assign flagValues = st_reg.flags;
	assign regValues = storeBus.contents;
	assign forceCompare = st_reg.forcePulse;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// independent decode of the data-space mirror, kept apart from ioAddr
	map_entry_t mirrorEntry;
	assign mirrorEntry = lookup(6'(reqAddr - DATA_SPACE_OFFSET));

	// a refused access writes nothing and answers as a miss
	sequence missAnswer;
		!storeBus.we ##1 (rspValid && !rspHit);
	endsequence

	sequence hitAnswer;
		##1 (rspValid && rspHit);
	endsequence

	bitRange_a: assert property (
		(taken && isBitOp && reqAddr[5:0] > BIT_IO_LAST) |-> missAnswer)
		else $error("bit op above low range was served");

	skipSet_a: assert property (
		(hit && reqCmd == SKIP_IF_IO_BIT_SET_INSTR) |->
		hitAnswer ##0 (rspSkip == $past(testBit)))
		else $error("skip-if-set decision wrong");

	skipClear_a: assert property (
		(hit && reqCmd == SKIP_IF_IO_BIT_CLEAR_INSTR) |->
		hitAnswer ##0 (rspSkip == !$past(testBit)))
		else $error("skip-if-clear decision wrong");

	flagClear_a: assert property (
		(hit && reqCmd == IO_WRITE && entry.kind == KIND_FLAG) |=>
		((st_reg.flags[$past(flagIdx)] & $past(clearBits)) ==
		($past(evSel) & $past(clearBits))))
		else $error("written one did not clear flag");

	flagZero_a: assert property (
		(hit && isWrite && entry.kind == KIND_FLAG && reqData == 8'h00 &&
		reqCmd != SET_IO_BIT_INSTR && evSel == 8'h00) |=>
		(st_reg.flags[$past(flagIdx)] == $past(curVal)))
		else $error("written zero changed a flag");

	flagBitOp_a: assert property (
		(hit && reqCmd == SET_IO_BIT_INSTR && entry.kind == KIND_FLAG &&
		evSel == 8'h00) |=>
		(st_reg.flags[$past(flagIdx)] == ($past(curVal) & ~$past(bitHot))))
		else $error("bit set disturbed other flags");

	storeBitOp_a: assert property (
		(hit && reqCmd == CLEAR_IO_BIT_INSTR && entry.kind == KIND_STORE) |=>
		((storeBus.contents[$past(flagIdx)] & $past(entry.mask)) ==
		($past(curVal) & ~$past(bitHot))))
		else $error("bit clear disturbed other bits");

	ioRead_a: assert property (
		(hit && reqCmd == IO_READ) |->
		hitAnswer ##0 (rspData == $past(curVal)))
		else $error("I/O read returned wrong data");

	dataMirror_a: assert property (
		(taken && reqCmd == DATA_LOAD && dataInIo &&
		mirrorEntry.kind != KIND_NONE) |->
		hitAnswer)
		else $error("data-space mirror missed");

	extSpace_a: assert property (
		(taken && !isIoCmd && reqAddr >= EXT_IO_FIRST) |-> missAnswer)
		else $error("extended space was served here");

	reservedRead_a: assert property (
		(taken && !isWrite && entry.kind == KIND_NONE) |->
		!storeBus.we ##1 (rspData == 8'h00 && !rspSkip))
		else $error("reserved read not zero");

	reservedWrite_a: assert property (
		(taken && isWrite && entry.kind == KIND_NONE) |->
		(!storeBus.we && clearBits == 8'h00) ##1 !rspHit)
		else $error("reserved write had an effect");

endmodule

`default_nettype wire

//--- io_space_pkg.sv
// Purpose: shared constants, types and the address map of the low I/O space
// Assumes: 8-bit registers, 6-bit I/O addresses, data space offset by 0x20
// Notes:   one table entry per implemented register; absent means reserved
`default_nettype none

package io_space_pkg;

	// ------------------------------------------------------------------
	// widths and address ranges
	// ------------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int IO_ADDR_W = 6;
	localparam int NUM_STORE = 18;
	localparam int NUM_FLAG = 5;
	localparam int NUM_PORT = 3;
	localparam int MAP_LEN = 26;
	localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;
	localparam logic [7:0] EXT_IO_FIRST = 8'h60;
	localparam logic [7:0] EXT_IO_LAST = 8'hFF;
	localparam logic [5:0] BIT_IO_LAST = 6'h1F;
	localparam logic [5:0] IO_LAST = 6'h3F;

	// ------------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------------
	localparam logic [5:0] OFF_TIMER0_CONTROL_B = 6'h25;
	localparam int FORCE_LSB = 6;
	localparam int FORCE_MSB = 7;
	localparam logic [7:0] RESET_RW = 8'h00;
	localparam logic [7:0] RESET_FLAG = 8'h00;
	localparam logic [7:0] RESET_PIN = 8'h00;

	// ------------------------------------------------------------------
	// commands from the core and kinds of register
	// ------------------------------------------------------------------
	// data loads and stores cover the indirect, direct and displaced forms
	typedef enum logic [2:0] {
		IO_READ,
		IO_WRITE,
		SET_IO_BIT_INSTR,
		CLEAR_IO_BIT_INSTR,
		SKIP_IF_IO_BIT_SET_INSTR,
		SKIP_IF_IO_BIT_CLEAR_INSTR,
		DATA_LOAD,
		DATA_STORE
	} cmd_t;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_STORE,
		KIND_FLAG,
		KIND_PIN
	} kind_t;

	typedef struct packed {
		logic [5:0] addr;
		kind_t kind;
		logic [4:0] idx;
		logic [7:0] mask;
	} map_entry_t;

	// ------------------------------------------------------------------
	// address map: I/O address, kind, slot, implemented bits
	// ------------------------------------------------------------------
	localparam map_entry_t IO_MAP [MAP_LEN] = '{
		'{6'h03, KIND_PIN, 5'h00, 8'hFF},   // port_b_input_pins
		'{6'h04, KIND_STORE, 5'h00, 8'hFF}, // port_b_direction
		'{6'h05, KIND_STORE, 5'h01, 8'hFF}, // port_b_output
		'{6'h06, KIND_PIN, 5'h01, 8'h7F},   // port_c_input_pins
		'{6'h07, KIND_STORE, 5'h02, 8'h7F}, // port_c_direction
		'{6'h08, KIND_STORE, 5'h03, 8'h7F}, // port_c_output
		'{6'h09, KIND_PIN, 5'h02, 8'hFF},   // port_d_input_pins
		'{6'h0A, KIND_STORE, 5'h04, 8'hFF}, // port_d_direction
		'{6'h0B, KIND_STORE, 5'h05, 8'hFF}, // port_d_output
		'{6'h15, KIND_FLAG, 5'h00, 8'h07},  // timer0_event_flags
		'{6'h16, KIND_FLAG, 5'h01, 8'h27},  // timer1_event_flags
		'{6'h17, KIND_FLAG, 5'h02, 8'h07},  // timer2_event_flags
		'{6'h1B, KIND_FLAG, 5'h03, 8'h07},  // pin_change_event_flags
		'{6'h1C, KIND_FLAG, 5'h04, 8'h03},  // external_irq_flags
		'{6'h1D, KIND_STORE, 5'h06, 8'h03}, // external_irq_mask
		'{6'h21, KIND_STORE, 5'h07, 8'hFF}, // eeprom_address_low
		'{6'h22, KIND_STORE, 5'h08, 8'hFF}, // eeprom_address_high
		'{6'h23, KIND_STORE, 5'h09, 8'hFF}, // general_timer_control
		'{6'h24, KIND_STORE, 5'h0A, 8'hF3}, // timer0_control_a
		'{OFF_TIMER0_CONTROL_B, KIND_STORE, 5'h0B, 8'h0F},
		'{6'h26, KIND_STORE, 5'h0C, 8'hFF}, // timer0_count
		'{6'h27, KIND_STORE, 5'h0D, 8'hFF}, // timer0_compare_a
		'{6'h28, KIND_STORE, 5'h0E, 8'hFF}, // timer0_compare_b
		'{6'h2A, KIND_STORE, 5'h0F, 8'hFF}, // scratch_register_1
		'{6'h2B, KIND_STORE, 5'h10, 8'hFF}, // scratch_register_2
		'{6'h2C, KIND_STORE, 5'h11, 8'hFF}  // serial_periph_control
	};

	// address decode, shared by the datapath and its checks
	function automatic map_entry_t lookup(input logic [5:0] addr);
		map_entry_t e;
		e = '{addr: addr, kind: KIND_NONE, idx: 5'h00, mask: 8'h00};
		for (int i = 0; i < MAP_LEN; i++) begin
			if (IO_MAP[i].addr == addr) begin
				e = IO_MAP[i];
			end
		end
		return e;
	endfunction

	// implemented bits of flag register n
	function automatic logic [7:0] flagMask(input int n);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < MAP_LEN; i++) begin
			if (IO_MAP[i].kind == KIND_FLAG && int'(IO_MAP[i].idx) == n) begin
				m = IO_MAP[i].mask;
			end
		end
		return m;
	endfunction

endpackage

`default_nettype wire

//--- store_if.sv
// Purpose: carries the write port, read port and contents of the slot store
// Assumes: one writer and one reader, both on the core clock
// Notes:   contents is the whole array, straight from the store flops
`timescale 1ns/10ps
`default_nettype none

interface store_if #(
	parameter int W = 8,
	parameter int N = 18
);
	localparam int AW = (N > 1) ? $clog2(N) : 1;
	logic we;
	logic [AW-1:0] waddr;
	logic [W-1:0] wdata;
	logic re;
	logic [AW-1:0] raddr;
	logic [W-1:0] rdata;
	logic [N-1:0][W-1:0] contents;

	modport user (output we, waddr, wdata, re, raddr, input rdata, contents);
	modport store (input we, waddr, wdata, re, raddr, output rdata, contents);
endinterface

`default_nettype wire

//--- reg_slot_store.sv
// Purpose: small register array behind the read/write I/O locations
// Assumes: write and read strobes already qualified by the clock enable
// Notes:   read data is registered; a same-cycle write is not seen by it
`timescale 1ns/10ps
`default_nettype none

module reg_slot_store #(
	parameter int W = 8,
	parameter int N = 18,
	parameter logic [W-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic sys_rst,
	store_if.store bus
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [N-1:0][W-1:0] mem;
		logic [W-1:0] rdata;
	} store_state_t;

	store_state_t st_reg;
	store_state_t st_next;

	if (N < 1 || W < 1) begin : badSize
		$error("reg_slot_store needs positive N and W");
	end

	// read returns the old word, so a read-modify-write sees one value
	always_comb begin
		st_next = st_reg;
		if (bus.re) begin
			st_next.rdata = st_reg.mem[bus.raddr];
		end
		if (bus.we) begin
			st_next.mem[bus.waddr] = bus.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '{mem: {N{RESET_VALUE}}, rdata: RESET_VALUE};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign bus.rdata = st_reg.rdata;
	assign bus.contents = st_reg.mem;

endmodule

`default_nettype wire

//--- core_model.sv
// Purpose: processor core stand-in that issues register requests
// Assumes: answer is registered on the same enabled edge that takes the request
// Notes:   released address, bit and data lines show inverted values; the command keeps its value
`timescale 1ns/10ps
`default_nettype none

module core_model (
	input wire logic clk,
	output var logic reqValid,
	output var io_space_pkg::cmd_t reqCmd,
	output var logic [7:0] reqAddr,
	output var logic [2:0] reqBit,
	output var logic [7:0] reqData,
	input wire logic rspValid,
	input wire logic rspHit,
	input wire logic rspSkip,
	input wire logic [7:0] rspData
);
	import io_space_pkg::*;

	// idle until the first request
	initial begin
		reqValid = 1'b0;
		reqCmd = IO_READ;
		reqAddr = 8'h00;
		reqBit = 3'h0;
		reqData = 8'h00;
	end

	// ----------------------------------------
	// one request, held to its taking edge
	// ----------------------------------------
	// callers may also pass reserved locations and set reserved bits
	task automatic access(input cmd_t c, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d, output logic v,
		output logic h, output logic s, output logic [7:0] q);
		@(posedge clk);
		reqValid <= 1'b1;
		reqCmd <= c;
		reqAddr <= a;
		reqBit <= b;
		reqData <= d;
		@(posedge clk);
		reqValid <= 1'b0;
		reqAddr <= ~a;
		reqBit <= ~b;
		reqData <= ~d;
		// let the answer flops settle before looking
		#1;
		v = rspValid;
		h = rspHit;
		s = rspSkip;
		q = rspData;
	endtask
endmodule

`default_nettype wire

//--- io_space_register_decoder_tb.sv
// Purpose: self-checking bench for the low I/O space decoder
// Assumes: clock enable held high throughout
// Notes:   expectations come from the local map tables below
`timescale 1ns/10ps
`default_nettype none

module io_space_register_decoder_tb;
	import io_space_pkg::*;

	// ----------------------------------------
	// signals and map tables
	// ----------------------------------------
	logic clk, ce, sys_rst, reqValid, rspValid, rspHit, rspSkip;
	cmd_t reqCmd;
	logic [7:0] reqAddr, reqData, rspData, pat;
	logic [2:0] reqBit;
	logic [1:0] forceCompare;
	logic [NUM_PORT-1:0][7:0] portPins;
	logic [NUM_FLAG-1:0][7:0] flagEvents, flagValues;
	logic [NUM_STORE-1:0][7:0] regValues;
	logic v, h, s;
	logic [7:0] q;
	int fails, cmp_count, cycles, i;
	// only implemented locations are written
	localparam logic [5:0] SA [18] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0A,
		6'h0B, 6'h1D, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
		6'h28, 6'h2A, 6'h2B, 6'h2C};
	localparam logic [7:0] SM [18] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF,
		8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hF3, 8'h0F, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF};

	io_space_register_decoder io_space_register_decoder_inst (.clk(clk),
		.ce(ce), .sys_rst(sys_rst), .reqValid(reqValid), .reqCmd(reqCmd),
		.reqAddr(reqAddr), .reqBit(reqBit), .reqData(reqData),
		.rspValid(rspValid), .rspHit(rspHit), .rspSkip(rspSkip),
		.rspData(rspData), .portPins(portPins), .flagEvents(flagEvents),
		.flagValues(flagValues), .regValues(regValues),
		.forceCompare(forceCompare));

	core_model core_model_inst (.clk(clk), .reqValid(reqValid),
		.reqCmd(reqCmd), .reqAddr(reqAddr), .reqBit(reqBit),
		.reqData(reqData), .rspValid(rspValid), .rspHit(rspHit),
		.rspSkip(rspSkip), .rspData(rspData));

	// ----------------------------------------
	// checking tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// byte access: checks valid, hit and returned data
	task automatic req(input cmd_t c, input logic [7:0] a,
		input logic [7:0] d, input logic eh, input logic [7:0] ed);
		core_model_inst.access(c, a, 3'h0, d, v, h, s, q);
		chk("rspValid", 8'h01, {7'h00, v});
		chk("rspHit", {7'h00, eh}, {7'h00, h});
		chk("rspData", ed, q);
	endtask

	// bit access: checks valid, hit and skip decision
	task automatic bop(input cmd_t c, input logic [7:0] a,
		input logic [2:0] b, input logic eh, input logic es);
		core_model_inst.access(c, a, b, 8'h00, v, h, s, q);
		chk("rspValid", 8'h01, {7'h00, v});
		chk("rspHit", {7'h00, eh}, {7'h00, h});
		chk("rspSkip", {7'h00, es}, {7'h00, s});
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// a stuck handshake would otherwise run forever
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			close_out();
		end
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		ce = 1'b1;
		sys_rst = 1'b1;
		portPins = '0;
		flagEvents = '0;
		fails = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		// reset contents, then data-space write and I/O read back
		for (i = 0; i < 18; i++) begin
			req(IO_READ, {2'b00, SA[i]}, 8'h00, 1'b1, 8'h00);
		end
		for (i = 0; i < 18; i++) begin
			pat = (8'hA5 ^ 8'(i)) & SM[i];
			req(DATA_STORE, {2'b00, SA[i]} + 8'h20, pat, 1'b1, 8'h00);
			req(IO_READ, {2'b00, SA[i]}, 8'h00, 1'b1, pat);
			chk("regValues", pat, regValues[i]);
		end
		// force bits pulse and are never stored
		req(IO_WRITE, 8'h25, 8'hC0, 1'b1, 8'h0E);
		chk("forceCompare", 8'h03, {6'h00, forceCompare});
		chk("timer0_control_b", 8'h00, regValues[11]);
		// single-bit writes, low range only
		bop(SET_IO_BIT_INSTR, 8'h05, 3'd1, 1'b1, 1'b0);
		chk("forceCompare", 8'h00, {6'h00, forceCompare});
		bop(CLEAR_IO_BIT_INSTR, 8'h05, 3'd2, 1'b1, 1'b0);
		chk("port_b_output", 8'hA2, regValues[1]);
		bop(SET_IO_BIT_INSTR, 8'h2A, 3'd0, 1'b0, 1'b0);
		chk("scratch_register_1", 8'hAA, regValues[15]);
		// raise flags, then clear two timer0 flags by written ones
		@(posedge clk);
		flagEvents[0] <= 8'h07;
		flagEvents[1] <= 8'hFF;
		flagEvents[4] <= 8'hFF;
		@(posedge clk);
		flagEvents <= '0;
		@(posedge clk);
		#1;
		chk("timer0_event_flags", 8'h07, flagValues[0]);
		chk("timer1_event_flags", 8'h27, flagValues[1]);
		chk("external_irq_flags", 8'h03, flagValues[4]);
		req(IO_WRITE, 8'h15, 8'h02, 1'b1, 8'h07);
		chk("timer0_event_flags", 8'h05, flagValues[0]);
		req(IO_WRITE, 8'h15, 8'h00, 1'b1, 8'h05);
		chk("timer0_event_flags", 8'h05, flagValues[0]);
		bop(SET_IO_BIT_INSTR, 8'h15, 3'd0, 1'b1, 1'b0);
		chk("timer0_event_flags", 8'h04, flagValues[0]);
		bop(CLEAR_IO_BIT_INSTR, 8'h15, 3'd2, 1'b1, 1'b0);
		chk("timer0_event_flags", 8'h04, flagValues[0]);
		chk("timer1_event_flags", 8'h27, flagValues[1]);
		// pin levels need the synchroniser delay before testing
		@(posedge clk);
		portPins[0] <= 8'h5A;
		portPins[1] <= 8'hFF;
		repeat (6) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			bop(SKIP_IF_IO_BIT_SET_INSTR, 8'h06, 3'(i), 1'b1, i != 7);
			pat = 8'h5A >> i;
			bop(SKIP_IF_IO_BIT_SET_INSTR, 8'h03, 3'(i), 1'b1, pat[0]);
			bop(SKIP_IF_IO_BIT_CLEAR_INSTR, 8'h03, 3'(i), 1'b1, !pat[0]);
		end
		bop(SKIP_IF_IO_BIT_SET_INSTR, 8'h2A, 3'd1, 1'b0, 1'b0);
		req(DATA_LOAD, 8'h23, 8'h00, 1'b1, 8'h5A);
		req(IO_READ, 8'h06, 8'h00, 1'b1, 8'h7F);
		// extended, working and reserved locations miss; an I/O read of 0x6A wraps to 0x2A and hits
		req(DATA_LOAD, 8'h60, 8'h00, 1'b0, 8'h00);
		req(DATA_LOAD, 8'hFF, 8'h00, 1'b0, 8'h00);
		req(DATA_LOAD, 8'h10, 8'h00, 1'b0, 8'h00);
		req(IO_READ, 8'h6A, 8'h00, 1'b1, 8'hAA);
		req(IO_READ, 8'h00, 8'h00, 1'b0, 8'h00);
		req(IO_READ, 8'h29, 8'h00, 1'b0, 8'h00);
		req(IO_READ, 8'h3F, 8'h00, 1'b0, 8'h00);
		req(DATA_LOAD, 8'h49, 8'h00, 1'b0, 8'h00);
		chk("scratch_register_1", 8'hAA, regValues[15]);
		close_out();
	end
endmodule

`default_nettype wire
